// ---- hw/ptg_consts.vh ----
// constants for the pulse start timing generator: offsets, fields, resets and divider masks
`ifndef PTG_CONSTS_VH
`define PTG_CONSTS_VH
// register byte offsets on the bus
`define PTG_OFS_GEN0_CTRL 12'h000
`define PTG_OFS_GEN1_CTRL 12'h004
`define PTG_OFS_COUNT 12'h008
`define PTG_OFS_CMP_BASE 12'h020
// compare registers occupy 0x020..0x03c, selected by haddr[11:5] == page
`define PTG_CMP_PAGE 7'h01
// control register field positions
`define PTG_STOP_HI 15
`define PTG_STOP_LO 12
`define PTG_CSEL_HI 11
`define PTG_CSEL_LO 10
`define PTG_RUN_BIT 9
`define PTG_GO_BIT 8
// reset and fixed values
`define PTG_CSEL_RST 2'h0
`define PTG_CMP_RST 8'h00
`define PTG_CMP_OFF 8'h00
`define PTG_CNT_FIRST 8'h00
`define PTG_CNT_LAST 8'hff
`define PTG_STOP_READ 4'hf
// clock select codes and divider masks (divide by mask + 1)
`define PTG_CSEL_DIV2 2'h0
`define PTG_CSEL_DIV8 2'h1
`define PTG_CSEL_DIV32 2'h2
`define PTG_CSEL_DIV64 2'h3
`define PTG_MASK_DIV2 6'h01
`define PTG_MASK_DIV8 6'h07
`define PTG_MASK_DIV32 6'h1f
`define PTG_MASK_DIV64 6'h3f
`define PTG_PRE_ZERO 6'h00
`define PTG_PRE_ONE 6'h01
// bus answers
`define PTG_HRESP_OKAY 1'b0
`endif

// ---- hw/ptg_gen.v ----
// one timing generator: prescaler, one-shot 8-bit up-counter and four start signals
`timescale 1ns/1ps
`include "ptg_consts.vh"
module ptg_gen #(
   parameter NUM_CH = 4,
   parameter CNT_W = 8
) (
   input wire clk_in,
   input wire rst_n_in,
   input wire go_in,
   input wire [1:0] clk_sel_in,
   input wire [NUM_CH*CNT_W-1:0] cmp_in,
   input wire [NUM_CH-1:0] stop_in,
   output wire [NUM_CH-1:0] start_out,
   output wire running_out,
   output wire [CNT_W-1:0] count_out
);
   reg [5:0] pre_ff;
   reg [CNT_W-1:0] cnt_ff;
   reg run_ff;
   reg [NUM_CH-1:0] start_ff;
   reg [5:0] mask;
   wire tick;
   wire [CNT_W-1:0] cnt_inc;
   wire step;

   // divider mask from the clock select code
   always @* begin
      case (clk_sel_in)
         `PTG_CSEL_DIV2: mask = `PTG_MASK_DIV2;
         `PTG_CSEL_DIV8: mask = `PTG_MASK_DIV8;
         `PTG_CSEL_DIV32: mask = `PTG_MASK_DIV32;
         `PTG_CSEL_DIV64: mask = `PTG_MASK_DIV64;
         default: mask = `PTG_MASK_DIV2;
      endcase
   end

   assign tick = ((pre_ff & mask) == mask);
   assign cnt_inc = cnt_ff + 1'b1;
   assign step = run_ff && tick && !go_in;

   // prescaler restarts on go so the first count step lands a full divided period later
   always @(posedge clk_in) begin
      if (!rst_n_in || go_in) begin
         pre_ff <= `PTG_PRE_ZERO;
      end else begin
         pre_ff <= pre_ff + `PTG_PRE_ONE;
      end
   end

   // one-shot counter: load zero on go, step on each divided tick, stop at the top
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         cnt_ff <= `PTG_CNT_FIRST;
         run_ff <= 1'b0;
      end else if (go_in) begin
         cnt_ff <= `PTG_CNT_FIRST;
         run_ff <= 1'b1;
      end else if (step) begin
         cnt_ff <= cnt_inc;
         if (cnt_inc == `PTG_CNT_LAST) begin
            run_ff <= 1'b0;
         end
      end
   end

   // start signals: set on the step that reaches the compare value, cleared by stop writes
   genvar i;
   generate
      for (i = 0; i < NUM_CH; i = i + 1) begin : g_ch
         wire hit;
         assign hit = step && (cmp_in[i*CNT_W +: CNT_W] != `PTG_CMP_OFF) &&
            (cnt_inc == cmp_in[i*CNT_W +: CNT_W]);
         always @(posedge clk_in) begin
            if (!rst_n_in) begin
               start_ff[i] <= 1'b0;
            end else if (stop_in[i]) begin
               start_ff[i] <= 1'b0;
            end else if (hit) begin
               start_ff[i] <= 1'b1;
            end
         end
      end
   endgenerate

   assign start_out = start_ff;
   assign running_out = run_ff;
   assign count_out = cnt_ff;
endmodule

// ---- hw/ptg_top.v ----
// pulse start timing generator with two generators behind an ahb-lite register slave
`timescale 1ns/1ps
`include "ptg_consts.vh"
module ptg_top #(
   parameter NUM_CH = 8,
   parameter CNT_W = 8,
   parameter ADDR_W = 12
) (
   input wire clk_in,
   input wire rst_n_in,
   input wire hsel_in,
   input wire [31:0] haddr_in,
   input wire [1:0] htrans_in,
   input wire hwrite_in,
   input wire [2:0] hsize_in,
   input wire [31:0] hwdata_in,
   input wire hready_in,
   output wire hreadyout_out,
   output wire hresp_out,
   output wire [31:0] hrdata_out,
   output wire [NUM_CH-1:0] pulse_channel_start_out
);
   localparam HALF = NUM_CH / 2;
   // offsets held at address width so the word decode compares equal widths
   localparam [ADDR_W-1:0] OFS_GEN0 = `PTG_OFS_GEN0_CTRL;
   localparam [ADDR_W-1:0] OFS_GEN1 = `PTG_OFS_GEN1_CTRL;
   localparam [ADDR_W-1:0] OFS_COUNT = `PTG_OFS_COUNT;

   // bus pipeline state
   reg wr_pend_ff;
   reg rd_pend_ff;
   reg [ADDR_W-1:0] addr_ff;
   reg hreadyout_ff;
   reg [31:0] hrdata_ff;
   reg [31:0] nxt_hrdata;
   reg [NUM_CH-1:0] start_ff;

   // software visible state
   reg [1:0] gen0_clk_sel_ff;
   reg [1:0] gen1_clk_sel_ff;
   reg [CNT_W-1:0] cmp_ff [0:NUM_CH-1];

   // decode of the captured address
   wire take;
   wire hit_gen0;
   wire hit_gen1;
   wire hit_count;
   wire hit_cmp;
   wire [2:0] cmp_idx;

   // write strobes toward the generators
   wire gen0_count_go;
   wire gen1_count_go;
   wire [HALF-1:0] gen0_stop;
   wire [HALF-1:0] gen1_stop;

   // generator results
   wire [HALF-1:0] gen0_start;
   wire [HALF-1:0] gen1_start;
   wire gen0_running;
   wire gen1_running;
   wire [CNT_W-1:0] gen0_count;
   wire [CNT_W-1:0] gen1_count;
   wire [HALF*CNT_W-1:0] gen0_cmp;
   wire [HALF*CNT_W-1:0] gen1_cmp;

   // an address phase is taken only when the bus is ready and a transfer is requested
   assign take = hsel_in && htrans_in[1] && hready_in;

   // address phase capture; reads get one wait state so a write just before is seen
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         wr_pend_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         addr_ff <= {ADDR_W{1'b0}};
         hreadyout_ff <= 1'b1;
      end else if (rd_pend_ff) begin
         rd_pend_ff <= 1'b0;
         hreadyout_ff <= 1'b1;
      end else begin
         wr_pend_ff <= take && hwrite_in;
         rd_pend_ff <= take && !hwrite_in;
         hreadyout_ff <= !(take && !hwrite_in);
         if (take) begin
            addr_ff <= haddr_in[ADDR_W-1:0];
         end
      end
   end

   // register decode on the captured word address
   assign hit_gen0 = (addr_ff[ADDR_W-1:2] == OFS_GEN0[ADDR_W-1:2]);
   assign hit_gen1 = (addr_ff[ADDR_W-1:2] == OFS_GEN1[ADDR_W-1:2]);
   assign hit_count = (addr_ff[ADDR_W-1:2] == OFS_COUNT[ADDR_W-1:2]);
   assign hit_cmp = (addr_ff[ADDR_W-1:5] == `PTG_CMP_PAGE);
   assign cmp_idx = addr_ff[4:2];

   // go and stop act only during a write data phase; they store nothing
   assign gen0_count_go = wr_pend_ff && hit_gen0 && hwdata_in[`PTG_GO_BIT];
   assign gen1_count_go = wr_pend_ff && hit_gen1 && hwdata_in[`PTG_GO_BIT];

   // a zero in a stop field is the request; ones leave the start signal alone
   assign gen0_stop = {HALF{wr_pend_ff && hit_gen0}} &
      ~hwdata_in[`PTG_STOP_HI:`PTG_STOP_LO];
   assign gen1_stop = {HALF{wr_pend_ff && hit_gen1}} &
      ~hwdata_in[`PTG_STOP_HI:`PTG_STOP_LO];

   // clock select fields; changing them mid count is up to software to avoid
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         gen0_clk_sel_ff <= `PTG_CSEL_RST;
         gen1_clk_sel_ff <= `PTG_CSEL_RST;
      end else if (wr_pend_ff) begin
         if (hit_gen0) begin
            gen0_clk_sel_ff <= hwdata_in[`PTG_CSEL_HI:`PTG_CSEL_LO];
         end
         if (hit_gen1) begin
            gen1_clk_sel_ff <= hwdata_in[`PTG_CSEL_HI:`PTG_CSEL_LO];
         end
      end
   end

   // compare registers, one per channel; even channels feed gen 0, odd ones gen 1
   genvar c;
   generate
      for (c = 0; c < NUM_CH; c = c + 1) begin : g_cmp
         always @(posedge clk_in) begin
            if (!rst_n_in) begin
               cmp_ff[c] <= `PTG_CMP_RST;
            end else if (wr_pend_ff && hit_cmp && (cmp_idx == c)) begin
               cmp_ff[c] <= hwdata_in[CNT_W-1:0];
            end
         end
         if (c % 2 == 0) begin : g_even
            assign gen0_cmp[(c/2)*CNT_W +: CNT_W] = cmp_ff[c];
         end else begin : g_odd
            assign gen1_cmp[(c/2)*CNT_W +: CNT_W] = cmp_ff[c];
         end
      end
   endgenerate

   // generator 0 serves the even channels
   ptg_gen #(
      .NUM_CH(HALF),
      .CNT_W(CNT_W)
   ) u_gen0 (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .go_in(gen0_count_go),
      .clk_sel_in(gen0_clk_sel_ff),
      .cmp_in(gen0_cmp),
      .stop_in(gen0_stop),
      .start_out(gen0_start),
      .running_out(gen0_running),
      .count_out(gen0_count)
   );

   // generator 1 serves the odd channels
   ptg_gen #(
      .NUM_CH(HALF),
      .CNT_W(CNT_W)
   ) u_gen1 (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .go_in(gen1_count_go),
      .clk_sel_in(gen1_clk_sel_ff),
      .cmp_in(gen1_cmp),
      .stop_in(gen1_stop),
      .start_out(gen1_start),
      .running_out(gen1_running),
      .count_out(gen1_count)
   );

   // interleave the start signals: local bit k of gen 0 is channel 2k, of gen 1 channel 2k+1
   genvar k;
   generate
      for (k = 0; k < HALF; k = k + 1) begin : g_map
         always @(posedge clk_in) begin
            if (!rst_n_in) begin
               start_ff[2*k] <= 1'b0;
               start_ff[2*k+1] <= 1'b0;
            end else begin
               start_ff[2*k] <= gen0_start[k];
               start_ff[2*k+1] <= gen1_start[k];
            end
         end
      end
   endgenerate

   // read mux; stop bits read one, go bit reads zero, unmapped reads zero
   always @* begin
      nxt_hrdata = 32'h00000000;
      if (hit_gen0) begin
         nxt_hrdata[`PTG_STOP_HI:`PTG_STOP_LO] = `PTG_STOP_READ;
         nxt_hrdata[`PTG_CSEL_HI:`PTG_CSEL_LO] = gen0_clk_sel_ff;
         nxt_hrdata[`PTG_RUN_BIT] = gen0_running;
         nxt_hrdata[`PTG_GO_BIT] = 1'b0;
      end else if (hit_gen1) begin
         nxt_hrdata[`PTG_STOP_HI:`PTG_STOP_LO] = `PTG_STOP_READ;
         nxt_hrdata[`PTG_CSEL_HI:`PTG_CSEL_LO] = gen1_clk_sel_ff;
         nxt_hrdata[`PTG_RUN_BIT] = gen1_running;
         nxt_hrdata[`PTG_GO_BIT] = 1'b0;
      end else if (hit_count) begin
         nxt_hrdata[CNT_W-1:0] = gen0_count;
         nxt_hrdata[2*CNT_W-1:CNT_W] = gen1_count;
      end else if (hit_cmp) begin
         nxt_hrdata[CNT_W-1:0] = cmp_ff[cmp_idx];
      end
   end

   // read data is registered during the wait state and held until the next read
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         hrdata_ff <= 32'h00000000;
      end else if (rd_pend_ff) begin
         hrdata_ff <= nxt_hrdata;
      end
   end

   // every answer is okay; hsize is not checked, only word access is meaningful
   assign hreadyout_out = hreadyout_ff;
   assign hresp_out = `PTG_HRESP_OKAY;
   assign hrdata_out = hrdata_ff;
   assign pulse_channel_start_out = start_ff;
endmodule

// ---- sim/ptg_props.sv ----
// assertion checker for the pulse start timing generator top
`timescale 1ns/1ps
module ptg_props #(
   parameter NUM_CH = 8
) (
   input wire clk_in,
   input wire rst_n_in,
   input wire hsel_in,
   input wire [31:0] haddr_in,
   input wire [1:0] htrans_in,
   input wire hwrite_in,
   input wire [2:0] hsize_in,
   input wire [31:0] hwdata_in,
   input wire hready_in,
   input wire hreadyout_out,
   input wire hresp_out,
   input wire [31:0] hrdata_out,
   input wire [NUM_CH-1:0] pulse_channel_start_out
);
   logic wr_ph_ff;
   logic rd_ph_ff;
   logic [31:0] addr_ff;
   wire tk = hsel_in && htrans_in[1] && hready_in;
   wire apply = wr_ph_ff && hready_in;
   wire stop0 = apply && addr_ff[11:0] == 12'h000 && !hwdata_in[12];
   wire rd_done = rd_ph_ff && hreadyout_out;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // track the open data phase; a wait state keeps it open
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         wr_ph_ff <= 1'b0;
         rd_ph_ff <= 1'b0;
      end else if (hready_in) begin
         wr_ph_ff <= tk && hwrite_in;
         rd_ph_ff <= tk && !hwrite_in;
      end
      if (tk) addr_ff <= haddr_in;
   end
   a_resp_okay: assert property (hresp_out == 1'b0)
      else $error("slave gave a non okay response");
   a_read_wait: assert property (tk && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
      else $error("read wait state wrong");
   a_write_fast: assert property (tk && hwrite_in |=> hreadyout_out)
      else $error("write stalled");
   a_stop_ch0: assert property (stop0 |-> ##2 !pulse_channel_start_out[0])
      else $error("channel 0 start not negated");
   a_stop_ch7: assert property (apply && addr_ff[11:0] == 12'h004 && !hwdata_in[15]
      |-> ##2 !pulse_channel_start_out[7]) else $error("channel 7 start not negated");
   a_start_held: assert property ($fell(pulse_channel_start_out[0]) |-> $past(stop0, 2))
      else $error("channel 0 start dropped without a stop write");
   a_ctrl_read: assert property (rd_done && addr_ff[11:3] == 9'h0
      |-> hrdata_out[15:12] == 4'hf && !hrdata_out[8]) else $error("control read bits wrong");
   a_unmapped_zero: assert property (rd_done && addr_ff[11:0] == 12'h010 |-> hrdata_out == 32'h0)
      else $error("unmapped read not zero");
   a_reset_vals: assert property (disable iff (1'b0) !rst_n_in
      |=> pulse_channel_start_out == '0 && hreadyout_out && hrdata_out == 32'h0)
      else $error("reset state wrong");
   c_read: cover property (tk && !hwrite_in);
   c_stop0: cover property (stop0);
   c_rise6: cover property ($rose(pulse_channel_start_out[6]));
endmodule
bind ptg_top ptg_props #(.NUM_CH(NUM_CH)) u_props (
   .clk_in(clk_in),
   .rst_n_in(rst_n_in),
   .hsel_in(hsel_in),
   .haddr_in(haddr_in),
   .htrans_in(htrans_in),
   .hwrite_in(hwrite_in),
   .hsize_in(hsize_in),
   .hwdata_in(hwdata_in),
   .hready_in(hready_in),
   .hreadyout_out(hreadyout_out),
   .hresp_out(hresp_out),
   .hrdata_out(hrdata_out),
   .pulse_channel_start_out(pulse_channel_start_out)
);

// ---- sim/ptg_chan_model.sv ----
// pulse channel model: notes when each channel was told to start
`timescale 1ns/1ps
module ptg_chan_model (
   input wire clk_in,
   input wire [7:0] start_in
);
   int cyc = 0;
   int rise_cyc [8];
   logic [7:0] prev_ff = 8'h00;
   // a channel starts on the rising start signal and runs until it is negated
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      prev_ff <= start_in;
      for (int k = 0; k < 8; k++)
         if (start_in[k] && !prev_ff[k]) rise_cyc[k] <= cyc;
   end
endmodule

// ---- sim/ptg_top_tb.sv ----
// self-checking bench for the pulse start timing generator
`timescale 1ns/1ps
module ptg_top_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] rd;
   wire rdy;
   wire hresp;
   wire [31:0] hrdata;
   wire [7:0] st;
   int bad_count = 0;
   int n_tests = 0;
   int cyc = 0;
   int i;
   // rows: address, value written, value read back
   logic [31:0] rows [9][3] = '{
      '{32'h0, 32'h400, 32'hf400}, '{32'h0, 32'h800, 32'hf800},
      '{32'h0, 32'hc00, 32'hfc00}, '{32'h0, 32'h200, 32'hf000},
      '{32'h4, 32'hc00, 32'hfc00}, '{32'h4, 32'h200, 32'hf000},
      '{32'h20, 32'ha5, 32'ha5}, '{32'h3c, 32'h5a, 32'h5a}, '{32'h10, 32'hff, 32'h0}};
   ptg_top dut (
      .clk_in(clk),
      .rst_n_in(rst_n),
      .hsel_in(hsel),
      .haddr_in(haddr),
      .htrans_in(htrans),
      .hwrite_in(hwrite),
      .hsize_in(3'h2),
      .hwdata_in(hwdata),
      .hready_in(rdy),
      .hreadyout_out(rdy),
      .hresp_out(hresp),
      .hrdata_out(hrdata),
      .pulse_channel_start_out(st)
   );
   ptg_chan_model chans (.clk_in(clk), .start_in(st));
   always #20 clk = ~clk;
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // a hang shows as a mismatch rather than a silent stall; the /64 run alone is ~16400 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         bad_count++;
         print_verdict();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one single ahb-lite transfer, held until the slave is ready
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask
   task automatic rx(input logic [31:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   // poll the run monitor; restarting before it clears is not allowed
   task automatic wait_idle(input logic [31:0] a);
      bus(1'b0, a, 32'h0);
      for (i = 0; i < 8000 && rd[9] !== 1'b0; i++) bus(1'b0, a, 32'h0);
      chk(rd & 32'h200, 32'h0);
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk(st, 32'h0);
      rx(32'h0, 32'hf000);
      rx(32'h4, 32'hf000);
      $display("test reset done");
      for (int r = 0; r < 9; r++) begin
         bus(1'b1, rows[r][0], rows[r][1]);
         rx(rows[r][0], rows[r][2]);
      end
      $display("test register rows done");
      // compares: ch0 0x10, ch2 off, ch4 0xff, ch6 0x01, ch1 0x01, ch3 0x03
      bus(1'b1, 32'h20, 32'h10);
      bus(1'b1, 32'h28, 32'h00);
      bus(1'b1, 32'h30, 32'hff);
      bus(1'b1, 32'h38, 32'h01);
      bus(1'b1, 32'h24, 32'h01);
      bus(1'b1, 32'h2c, 32'h03);
      bus(1'b1, 32'h0, 32'hf100);
      rx(32'h0, 32'hf200);
      wait_idle(32'h0);
      rx(32'h8, 32'hff);
      chk(st, 32'h51);
      chk(chans.rise_cyc[0] - chans.rise_cyc[6], 32'd30);
      bus(1'b1, 32'h0, 32'ha000);
      repeat (2) @(posedge clk);
      chk(st, 32'h40);
      bus(1'b1, 32'h0, 32'h5000);
      repeat (2) @(posedge clk);
      chk(st, 32'h0);
      $display("test gen0 run and stop done");
      bus(1'b1, 32'h4, 32'h500);
      wait_idle(32'h4);
      rx(32'h8, 32'hffff);
      chk(st, 32'h8a);
      chk(chans.rise_cyc[3] - chans.rise_cyc[1], 32'd16);
      $display("test gen1 run done");
      // second run: the stop write lands on the edge where ch0 matches
      bus(1'b1, 32'h0, 32'hf100);
      repeat (30) @(posedge clk);
      bus(1'b1, 32'h0, 32'he000);
      wait_idle(32'h0);
      chk(st, 32'hda);
      $display("test stop against match done");
      // slow dividers: gen0 at /32, gen1 at /64; zero stop bits clear the old starts
      bus(1'b1, 32'h0, 32'h900);
      bus(1'b1, 32'h4, 32'hd00);
      wait_idle(32'h4);
      wait_idle(32'h0);
      rx(32'h8, 32'hffff);
      chk(st, 32'hdb);
      chk(chans.rise_cyc[0] - chans.rise_cyc[6], 32'd480);
      chk(chans.rise_cyc[3] - chans.rise_cyc[1], 32'd128);
      $display("test slow dividers done");
      // reset in the middle of a run clears starts, counters and the monitor
      bus(1'b1, 32'h0, 32'h100);
      repeat (10) @(posedge clk);
      chk(st, 32'hca);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk(st, 32'h0);
      rx(32'h0, 32'hf000);
      rx(32'h8, 32'h0);
      $display("test reset in mid run done");
      print_verdict();
   end
endmodule
